/* File: rtl/mac_pkg.sv */
// Shared constants and types of the multiply-accumulate unit
package mac_pkg;

  // ----------------------------------------
  // Widths and pipeline shape
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int SUM_W = 48;
  localparam int SUM_N = 4;
  localparam int PIPE_DEPTH = 4;
  localparam int PEND_N = PIPE_DEPTH - 1;

  // ----------------------------------------
  // Status/control register layout
  // ----------------------------------------
  localparam int SR_W = 8;
  localparam int SR_SU = 6;
  localparam int SR_FI = 5;
  localparam int SR_N = 3;
  localparam int SR_Z = 2;
  localparam int SR_V = 1;
  localparam int SR_EV = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ----------------------------------------
  // Address filter and data lanes
  // ----------------------------------------
  localparam logic [15:0] FILTER_RESET = 16'hffff;
  localparam logic [15:0] FILTER_HI = 16'hffff;
  localparam int UPPER_LO = 32;
  localparam int FRAC_LANE_LO = 24;
  localparam int FRAC_STORE_LO = 8;
  localparam int FRAC_LOAD_PAD = 8;
  localparam logic [1:0] SF_LEFT = 2'h1;
  localparam logic [1:0] SF_RIGHT = 2'h3;

  // ----------------------------------------
  // Operations issued by the operand pipeline
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_SIGNED_MULTIPLY = 4'h1,
    OP_UNSIGNED_MULTIPLY = 4'h2,
    OP_MULTIPLY_ADD = 4'h3,
    OP_MULTIPLY_SUB_OP = 4'h4,
    OP_LOAD_SUM = 4'h5,
    OP_STORE_SUM = 4'h6,
    OP_COPY_SUM = 4'h7,
    OP_LOAD_STATUS = 4'h8,
    OP_STORE_STATUS = 4'h9,
    OP_STATUS_TO_CC = 4'ha,
    OP_LOAD_FILTER = 4'hb,
    OP_STORE_FILTER = 4'hc,
    OP_LOAD_UPPER = 4'hd,
    OP_STORE_UPPER = 4'he
  } op_t;

  // One slot of the execution pipeline
  typedef struct packed {
    logic v;
    op_t op;
    logic [1:0] sel;
    logic [1:0] src;
    logic [1:0] sf;
    logic frac;
    logic uns;
    logic [3:0] dst;
    logic [47:0] val;
  } stage_t;

  localparam stage_t STAGE_IDLE = '0;

endpackage

/* File: rtl/mul_if.sv */
// Operand and product signals between the unit and its multiplier
`timescale 1ns/10ps
`default_nettype none
interface mul_if;
  logic [31:0] a;
  logic [31:0] b;
  logic is_signed;
  logic is_frac;
  logic [63:0] product;
  modport host (output a, b, is_signed, is_frac, input product);
  modport unit (input a, b, is_signed, is_frac, output product);
endinterface
`default_nettype wire

/* File: rtl/mul_stage.sv */
// Registered 32x32 multiplier, first execution stage
`timescale 1ns/10ps
`default_nettype none
module mul_stage (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Operands in, product out
  mul_if.unit m
);
  logic signed [32:0] a_ext;
  logic signed [32:0] b_ext;
  logic signed [65:0] full;
  logic [63:0] product_next;
  logic [63:0] product_reg;

  // Unsigned operands get a zero guard bit so one signed multiplier serves
  assign a_ext = $signed({m.is_signed & m.a[31], m.a});
  assign b_ext = $signed({m.is_signed & m.b[31], m.b});
  assign full = a_ext * b_ext;
  // Fractional products carry one sign bit too many, so shift left once
  assign product_next = m.is_frac ? {full[62:0], 1'b0} : full[63:0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      product_reg <= 64'h0;
    end else begin
      product_reg <= product_next;
    end
  end

  assign m.product = product_reg;
endmodule // mul_stage
`default_nettype wire

/* File: rtl/mac_unit.sv */
// Multiply-accumulate unit with four 48-bit sum registers
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// How it works
// - Status bits pick signed integer, unsigned integer or signed fraction
// - Signed multiply treats operands as two's complement
// - Unsigned multiply treats operands as unsigned
// - Multiply-add adds product to a sum register; subtract form subtracts
// - With-load forms also return a memory operand to a general register
// - Load writes a 32-bit register or immediate into a sum register
// - Store returns a sum register to a general register
// - Copy moves all 48 bits between sum registers
// - Status register is loaded, read, and copied to condition codes
// - Address filter register is loaded and read back
// - Upper bytes of sums 0,1 or 2,3 load from one word
// - Upper bytes of sums 0,1 or 2,3 read back as one word
// - First execution stage is the issue stage of the operand pipeline
// - Load, copy and multiply-accumulate issue back to back, no stall
// - Store right after a dependent multiply-accumulate waits 3 cycles
// - Store waits while its sum register is still in flight or a multiply result is writing back
// - Signed integer: two's complement, point right of the lsb
// - Unsigned integer: non-negative, point right of the lsb
// - Fraction: pattern with only the sign bit set means minus one
// - Fraction: all ones below the sign bit is the largest value
// - Enabled filter ANDs the operand address with ones over the filter
// - Filter keeps 16 low bits and reads back ones above them
// ----------------------------------------
module mac_unit #(
  parameter int PIPE_LEN = mac_pkg::PIPE_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Issue from the operand pipeline
  input wire logic issue_valid,
  input wire mac_pkg::op_t issue_op,
  output logic stall,
  // Operand selection
  input wire logic [1:0] sum_sel,
  input wire logic [1:0] src_sel,
  input wire logic [1:0] scale_sel,
  input wire logic word_size,
  input wire logic x_upper,
  input wire logic y_upper,
  input wire logic [31:0] opnd_x,
  input wire logic [31:0] opnd_y,
  input wire logic [3:0] dest_idx,
  // Memory operand of the with-load forms
  input wire logic with_load,
  input wire logic filter_en,
  input wire logic [31:0] ea_addr,
  input wire logic [31:0] mem_data,
  input wire logic [3:0] load_idx,
  // General register write-back
  output logic rd_valid,
  output logic [3:0] rd_idx,
  output logic [31:0] rd_data,
  // Memory load write-back and filtered address
  output logic ld_valid,
  output logic [3:0] ld_idx,
  output logic [31:0] ld_data,
  output logic [31:0] addr_out,
  // Condition code copy
  output logic cc_valid,
  output logic [4:0] cc_flags
);
  import mac_pkg::*;

  if (PIPE_LEN != 4) begin : g_bad_depth
    $error("mac_unit supports a pipeline depth of 4 only");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_mul(input op_t op);
    return op == OP_SIGNED_MULTIPLY || op == OP_UNSIGNED_MULTIPLY;
  endfunction

  function automatic logic is_mac(input op_t op);
    return op == OP_MULTIPLY_ADD || op == OP_MULTIPLY_SUB_OP;
  endfunction

  function automatic logic writes_sum(input op_t op);
    return is_mac(op) || op == OP_LOAD_SUM || op == OP_COPY_SUM;
  endfunction

  // Word operands take one half; fractions put it in the high half
  function automatic logic [31:0] pick(input logic [31:0] r,
      input logic up, input logic word, input logic frac, input logic uns);
    logic [15:0] half;
    half = up ? r[31:16] : r[15:0];
    if (!word) return r;
    if (frac) return {half, 16'h0000};
    if (uns) return {16'h0000, half};
    return {{16{half[15]}}, half};
  endfunction

  function automatic logic [47:0] widen(input logic [31:0] d,
      input logic frac, input logic uns);
    if (frac) return {{8{d[31]}}, d, 8'h00};
    if (uns) return {16'h0000, d};
    return {{16{d[31]}}, d};
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [47:0] sum_register_reg [SUM_N];
  logic [7:0] status_reg;
  logic [15:0] filter_reg;
  stage_t q_reg [PEND_N];
  stage_t wb;
  logic take;
  logic iss_frac;
  logic iss_uns;
  logic rd_clash;
  logic [PEND_N-1:0] pend_hit;
  logic [PEND_N-1:0] pend_any;
  logic [47:0] lane_val;
  logic [47:0] scale_val;
  logic [47:0] wb_sum;
  logic [31:0] upper_bytes_pair_low;
  logic [31:0] upper_bytes_pair_high;
  logic [31:0] sum_read;
  mul_if mi ();

  assign take = issue_valid && !stall;
  assign wb = q_reg[PEND_N-1];
  assign rd_clash = wb.v && is_mul(wb.op);

  // ----------------------------------------
  // Operand format
  // ----------------------------------------
  always_comb begin
    iss_frac = status_reg[SR_FI] && !is_mul(issue_op);
    if (is_mul(issue_op)) begin
      iss_uns = issue_op == OP_UNSIGNED_MULTIPLY;
    end else begin
      iss_uns = status_reg[SR_SU] && !status_reg[SR_FI];
    end
  end

  // Multiply starts in the issue cycle itself
  assign mi.a = pick(opnd_x, x_upper, word_size, iss_frac, iss_uns);
  assign mi.b = pick(opnd_y, y_upper, word_size, iss_frac, iss_uns);
  assign mi.is_signed = !iss_uns;
  assign mi.is_frac = iss_frac;

  mul_stage u_mul (
    .sys_clk(sys_clk),
    .rst(rst),
    .m(mi.unit)
  );

  // ----------------------------------------
  // Hazard detection
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PEND_N; gi++) begin : g_pend
      assign pend_any[gi] = q_reg[gi].v;
      assign pend_hit[gi] = q_reg[gi].v && writes_sum(q_reg[gi].op) &&
        q_reg[gi].sel == sum_sel;
    end
  endgenerate

  // Sum and filter writers never stall; stores and status or upper loads wait on in-flight state
  always_comb begin
    stall = 1'b0;
    case (issue_op)
      OP_STORE_SUM: stall = |pend_hit || rd_clash;
      OP_STORE_FILTER: stall = rd_clash;
      OP_STORE_STATUS: stall = |pend_any || rd_clash;
      OP_STORE_UPPER: stall = |pend_any || rd_clash;
      OP_LOAD_STATUS: stall = |pend_any;
      OP_STATUS_TO_CC: stall = |pend_any;
      OP_LOAD_UPPER: stall = |pend_any;
      default: stall = 1'b0;
    endcase
    if (!issue_valid) begin
      stall = 1'b0;
    end
  end

  // ----------------------------------------
  // Execution pipeline
  // ----------------------------------------
  always_comb begin
    lane_val = q_reg[0].val;
    if (is_mac(q_reg[0].op) && q_reg[0].frac) begin
      lane_val = {{8{mi.product[63]}}, mi.product[63:FRAC_LANE_LO]};
    end else if (is_mac(q_reg[0].op)) begin
      lane_val = mi.product[47:0];
    end else if (is_mul(q_reg[0].op)) begin
      lane_val = {16'h0000, mi.product[31:0]};
    end
  end

  // Scaling applies to integer multiply-accumulate products only
  always_comb begin
    scale_val = q_reg[1].val;
    if (is_mac(q_reg[1].op) && !q_reg[1].frac) begin
      if (q_reg[1].sf == SF_LEFT) begin
        scale_val = {q_reg[1].val[46:0], 1'b0};
      end else if (q_reg[1].sf == SF_RIGHT) begin
        scale_val = {q_reg[1].val[47] & !q_reg[1].uns, q_reg[1].val[47:1]};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_reg[0] <= STAGE_IDLE;
      q_reg[1] <= STAGE_IDLE;
      q_reg[2] <= STAGE_IDLE;
    end else begin
      q_reg[0] <= {take && (writes_sum(issue_op) || is_mul(issue_op)),
        issue_op, sum_sel, src_sel, scale_sel, iss_frac, iss_uns,
        dest_idx, widen(opnd_y, iss_frac, iss_uns)};
      q_reg[1] <= q_reg[0];
      q_reg[1].val <= lane_val;
      q_reg[2] <= q_reg[1];
      q_reg[2].val <= scale_val;
    end
  end

  // ----------------------------------------
  // Sum registers
  // ----------------------------------------
  always_comb begin
    wb_sum = sum_register_reg[wb.sel];
    case (wb.op)
      OP_MULTIPLY_ADD: wb_sum = sum_register_reg[wb.sel] + wb.val;
      OP_MULTIPLY_SUB_OP: wb_sum = sum_register_reg[wb.sel] - wb.val;
      OP_LOAD_SUM: wb_sum = wb.val;
      OP_COPY_SUM: wb_sum = sum_register_reg[wb.src];
      default: wb_sum = sum_register_reg[wb.sel];
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < SUM_N; k++) begin
        sum_register_reg[k] <= 48'h0;
      end
    end else begin
      if (wb.v && writes_sum(wb.op)) begin
        sum_register_reg[wb.sel] <= wb_sum;
      end
      // Upper loads wait for an empty pipeline, so they never collide
      if (take && issue_op == OP_LOAD_UPPER) begin
        for (int k = 0; k < 2; k++) begin
          sum_register_reg[{sum_sel[1], 1'(k)}][47:UPPER_LO] <=
            opnd_y[16*k +: 16];
        end
      end
    end
  end

  assign upper_bytes_pair_low = {sum_register_reg[1][47:UPPER_LO],
    sum_register_reg[0][47:UPPER_LO]};
  assign upper_bytes_pair_high = {sum_register_reg[3][47:UPPER_LO],
    sum_register_reg[2][47:UPPER_LO]};
  assign sum_read = status_reg[SR_FI] ?
    sum_register_reg[sum_sel][FRAC_STORE_LO +: 32] :
    sum_register_reg[sum_sel][31:0];

  // ----------------------------------------
  // Status and filter registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_reg <= STATUS_RESET;
    end else if (take && issue_op == OP_LOAD_STATUS) begin
      status_reg <= opnd_y[SR_W-1:0];
    end else if (wb.v && is_mac(wb.op)) begin
      status_reg[SR_N] <= wb_sum[47];
      status_reg[SR_Z] <= wb_sum == 48'h0;
      status_reg[SR_EV] <= wb.frac ?
        !(&wb_sum[47:39] || ~|wb_sum[47:39]) :
        !(&wb_sum[47:31] || ~|wb_sum[47:31]);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      filter_reg <= FILTER_RESET;
    end else if (take && issue_op == OP_LOAD_FILTER) begin
      filter_reg <= opnd_y[15:0];
    end
  end

  // ----------------------------------------
  // Write-back to the core
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_idx <= 4'h0;
      rd_data <= 32'h0;
    end else begin
      rd_valid <= 1'b0;
      if (rd_clash) begin
        rd_valid <= 1'b1;
        rd_idx <= wb.dst;
        rd_data <= wb.val[31:0];
      end else if (take) begin
        rd_idx <= dest_idx;
        case (issue_op)
          OP_STORE_SUM: begin
            rd_valid <= 1'b1;
            rd_data <= sum_read;
          end
          OP_STORE_STATUS: begin
            rd_valid <= 1'b1;
            rd_data <= {24'h0, status_reg};
          end
          OP_STORE_FILTER: begin
            rd_valid <= 1'b1;
            rd_data <= {FILTER_HI, filter_reg};
          end
          OP_STORE_UPPER: begin
            rd_valid <= 1'b1;
            rd_data <= sum_sel[1] ? upper_bytes_pair_high :
              upper_bytes_pair_low;
          end
          default: rd_valid <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cc_valid <= 1'b0;
      cc_flags <= 5'h0;
    end else begin
      cc_valid <= take && issue_op == OP_STATUS_TO_CC;
      if (take && issue_op == OP_STATUS_TO_CC) begin
        cc_flags <= {1'b0, status_reg[SR_N:SR_EV]};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ld_valid <= 1'b0;
      ld_idx <= 4'h0;
      ld_data <= 32'h0;
      addr_out <= 32'h0;
    end else begin
      ld_valid <= take && is_mac(issue_op) && with_load;
      if (take && is_mac(issue_op) && with_load) begin
        ld_idx <= load_idx;
        ld_data <= mem_data;
        addr_out <= filter_en ? ea_addr & {FILTER_HI, filter_reg} :
          ea_addr;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic prev_mac_reg;
  logic [1:0] prev_sel_reg;
  logic [31:0] prod_lo;
  logic [47:0] ld_ext;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_mac_reg <= 1'b0;
      prev_sel_reg <= 2'h0;
    end else begin
      prev_mac_reg <= take && is_mac(issue_op);
      prev_sel_reg <= sum_sel;
    end
  end

  assign prod_lo = 32'(opnd_x * opnd_y);
  assign ld_ext = widen(opnd_y, 1'b0, 1'b0);

  sequence s_dep_store;
    prev_mac_reg && issue_valid && issue_op == OP_STORE_SUM &&
      sum_sel == prev_sel_reg;
  endsequence

  sequence s_mul_issue;
    take && issue_op == OP_SIGNED_MULTIPLY && !word_size;
  endsequence

  property p_store_stall;
    @(posedge sys_clk) disable iff (rst)
      s_dep_store |-> stall [*3] ##1 !stall;
  endproperty
  a_store_stall: assert property (p_store_stall)
    else $error("dependent store did not wait three cycles");

  property p_no_stall;
    @(posedge sys_clk) disable iff (rst)
      issue_valid && (writes_sum(issue_op)) |-> !stall;
  endproperty
  a_no_stall: assert property (p_no_stall)
    else $error("accumulating operation stalled");

  property p_mul_result;
    @(posedge sys_clk) disable iff (rst)
      s_mul_issue |-> ##4 rd_valid && rd_data == $past(prod_lo, 4);
  endproperty
  a_mul_result: assert property (p_mul_result)
    else $error("signed multiply result wrong or late");

  property p_load_sum;
    @(posedge sys_clk) disable iff (rst)
      take && issue_op == OP_LOAD_SUM && status_reg[6:5] == 2'h0 |->
        ##4 sum_register_reg[$past(sum_sel, 4)] == $past(ld_ext, 4);
  endproperty
  a_load_sum: assert property (p_load_sum)
    else $error("loaded sum register value wrong");

  property p_copy;
    @(posedge sys_clk) disable iff (rst)
      wb.v && wb.op == OP_COPY_SUM |=>
        sum_register_reg[$past(wb.sel)] == $past(sum_register_reg[wb.src]);
  endproperty
  a_copy: assert property (p_copy)
    else $error("copy did not move all 48 bits");

  property p_filter_read;
    @(posedge sys_clk) disable iff (rst)
      take && issue_op == OP_STORE_FILTER |=>
        rd_valid && rd_data == {16'hffff, $past(filter_reg)};
  endproperty
  a_filter_read: assert property (p_filter_read)
    else $error("filter read back wrong");

  property p_filter_addr;
    @(posedge sys_clk) disable iff (rst)
      take && is_mac(issue_op) && with_load && filter_en |=>
        ld_valid && addr_out == ($past(ea_addr) & {16'hffff,
          $past(filter_reg)});
  endproperty
  a_filter_addr: assert property (p_filter_addr)
    else $error("filtered address wrong");

  property p_upper_read;
    @(posedge sys_clk) disable iff (rst)
      take && issue_op == OP_STORE_UPPER && !sum_sel[1] |=>
        rd_valid && rd_data == {$past(sum_register_reg[1][47:UPPER_LO]),
          $past(sum_register_reg[0][47:UPPER_LO])};
  endproperty
  a_upper_read: assert property (p_upper_read)
    else $error("upper byte pair read wrong");

endmodule // mac_unit
`default_nettype wire

/* File: testbench/core_issue_model.sv */
// Operand pipeline model that issues instructions to the unit
`timescale 1ns/10ps
`default_nettype none
module core_issue_model (
  // Clock and stall from the unit
  input wire logic sys_clk,
  input wire logic stall,
  // Issue bus
  output logic issue_valid,
  output var mac_pkg::op_t issue_op,
  output logic [1:0] sum_sel,
  output logic [1:0] src_sel,
  output logic [31:0] opnd_x,
  output logic [31:0] opnd_y,
  output logic [3:0] dest_idx
);
  import mac_pkg::*;
  initial begin
    issue_valid = 1'b0;
    issue_op = OP_NOP;
    sum_sel = 2'h0;
    src_sel = 2'h0;
    opnd_x = 32'h0;
    opnd_y = 32'h0;
    dest_idx = 4'h0;
  end
  // ------
  // Issue
  // ------
  // Called just after a rising edge, returns on the edge that takes it.
  // With last set, valid drops there, so no call may follow on that edge.
  task automatic go(input op_t op, input logic [1:0] s, input logic [1:0] c,
      input logic [31:0] x, input logic [31:0] y, input logic last,
      output int n);
    n = 0;
    issue_valid <= 1'b1;
    issue_op <= op;
    sum_sel <= s;
    src_sel <= c;
    opnd_x <= x;
    opnd_y <= y;
    dest_idx <= {c, s};
    @(negedge sys_clk);
    // Request held unchanged while stalled
    while (stall !== 1'b0 && n < 16) begin
      n++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    if (last) begin
      issue_valid <= 1'b0;
    end
  endtask
endmodule // core_issue_model
`default_nettype wire

/* File: testbench/multiply_accumulate_instruction_unit_tb.sv */
// Self-checking testbench of the multiply-accumulate unit
`timescale 1ns/10ps
`default_nettype none
module multiply_accumulate_instruction_unit_tb;
  import mac_pkg::*;
  logic sys_clk, rst, with_load, filter_en;
  logic [31:0] ea_addr, mem_data;
  logic [3:0] load_idx;
  logic issue_valid, stall, rd_valid, ld_valid, cc_valid;
  op_t issue_op;
  logic [1:0] sum_sel, src_sel;
  logic [31:0] opnd_x, opnd_y, rd_data, ld_data, addr_out;
  logic [3:0] dest_idx, rd_idx, ld_idx;
  logic [4:0] cc_flags;
  int num_errors = 0;
  int checks_done = 0;
  core_issue_model m (.sys_clk(sys_clk), .stall(stall),
    .issue_valid(issue_valid), .issue_op(issue_op), .sum_sel(sum_sel),
    .src_sel(src_sel), .opnd_x(opnd_x), .opnd_y(opnd_y),
    .dest_idx(dest_idx));
  // Half-word select and scaling are left out of this run
  mac_unit #(.PIPE_LEN(4)) dut (.sys_clk(sys_clk), .rst(rst),
    .issue_valid(issue_valid), .issue_op(issue_op), .stall(stall),
    .sum_sel(sum_sel), .src_sel(src_sel), .scale_sel(2'h0),
    .word_size(1'b0), .x_upper(1'b0), .y_upper(1'b0), .opnd_x(opnd_x),
    .opnd_y(opnd_y), .dest_idx(dest_idx), .with_load(with_load),
    .filter_en(filter_en), .ea_addr(ea_addr), .mem_data(mem_data),
    .load_idx(load_idx), .rd_valid(rd_valid), .rd_idx(rd_idx),
    .rd_data(rd_data), .ld_valid(ld_valid), .ld_idx(ld_idx),
    .ld_data(ld_data), .addr_out(addr_out), .cc_valid(cc_valid),
    .cc_flags(cc_flags));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ------
  // Helpers
  // ------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input op_t op, input logic [1:0] s, input logic [1:0] c,
      input logic [31:0] x, input logic [31:0] y, input logic l, output int n);
    m.go(op, s, c, x, y, l, n);
    if (n >= 16) begin
      num_errors++;
      $display("[FAIL] t=%0t stall count=%h limit=%h", $time, n, 16);
      wrap_up();
    end
  endtask
  // Bounded wait on a result pulse: 0 general, 1 memory load, 2 codes
  task automatic wv(input int w);
    int k;
    logic f;
    k = 0;
    f = 1'b0;
    while (f !== 1'b1 && k < 8) begin
      @(negedge sys_clk);
      k++;
      f = w == 0 ? rd_valid : (w == 1 ? ld_valid : cc_valid);
    end
    if (f !== 1'b1) begin
      num_errors++;
      $display("[FAIL] t=%0t valid=%h exp=%h", $time, f, 1'b1);
      wrap_up();
    end
  endtask
  task automatic xr(input op_t op, input logic [1:0] s, input logic [31:0] x,
      input logic [31:0] y, input logic [31:0] e, output int n);
    put(op, s, 2'h0, x, y, 1'b1, n);
    wv(0);
    chk(rd_data, e);
    chk({28'h0, rd_idx}, {30'h0, s});
    @(posedge sys_clk);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    int n;
    xr(OP_STORE_FILTER, 2'h0, 32'h0, 32'h0, 32'hffffffff, n);
    xr(OP_STORE_STATUS, 2'h0, 32'h0, 32'h0, 32'h0, n);
    xr(OP_STORE_SUM, 2'h3, 32'h0, 32'h0, 32'h0, n);
    $display("t_reset done");
  endtask
  task automatic t_modes();
    int n;
    for (int u = 0; u < 2; u++) begin
      put(OP_LOAD_STATUS, 2'h0, 2'h0, 32'h0, u ? 32'h40 : 32'h0, 1'b1, n);
      @(posedge sys_clk);
      put(OP_LOAD_SUM, 2'h0, 2'h0, 32'h0, 32'h0, 1'b0, n);
      put(OP_MULTIPLY_ADD, 2'h0, 2'h0, 32'hfffffffd, 32'h7, 1'b1, n);
      @(posedge sys_clk);
      xr(OP_STORE_UPPER, 2'h0, 32'h0, 32'h0, u ? 32'h6 : 32'hffff,
        n);
    end
    xr(OP_SIGNED_MULTIPLY, 2'h1, 32'hfffffffd, 32'h7, 32'hffffffeb, n);
    xr(OP_UNSIGNED_MULTIPLY, 2'h2, 32'hfffffffd, 32'h3, 32'hfffffff7,
      n);
    $display("t_modes done");
  endtask
  // Dependent stores: stall counts show how deep the pipeline is
  task automatic t_frac();
    int n;
    put(OP_LOAD_STATUS, 2'h0, 2'h0, 32'h0, 32'h20, 1'b1, n);
    @(posedge sys_clk);
    put(OP_LOAD_SUM, 2'h0, 2'h0, 32'h0, 32'h0, 1'b0, n);
    put(OP_MULTIPLY_ADD, 2'h0, 2'h0, 32'h80000000, 32'h7fffffff, 1'b0, n);
    xr(OP_STORE_SUM, 2'h0, 32'h0, 32'h0, 32'h80000001, n);
    chk(n, 32'h3);
    put(OP_MULTIPLY_SUB_OP, 2'h0, 2'h0, 32'h80000000, 32'h40000000, 1'b0, n);
    put(OP_LOAD_SUM, 2'h2, 2'h0, 32'h0, 32'h0, 1'b0, n);
    xr(OP_STORE_SUM, 2'h0, 32'h0, 32'h0, 32'hc0000001, n);
    chk(n, 32'h2);
    put(OP_LOAD_STATUS, 2'h0, 2'h0, 32'h0, 32'h0, 1'b1, n);
    @(posedge sys_clk);
    $display("t_frac done");
  endtask
  task automatic t_b2b();
    int n, t;
    put(OP_COPY_SUM, 2'h3, 2'h0, 32'h0, 32'h0, 1'b0, n);
    t = n;
    put(OP_MULTIPLY_ADD, 2'h2, 2'h0, 32'h2, 32'h3, 1'b0, n);
    t += n;
    put(OP_LOAD_SUM, 2'h0, 2'h0, 32'h0, 32'h0, 1'b0, n);
    t += n;
    put(OP_LOAD_FILTER, 2'h0, 2'h0, 32'h0, 32'hffff, 1'b0, n);
    t += n;
    put(OP_LOAD_SUM, 2'h1, 2'h0, 32'h0, 32'h80000001, 1'b0, n);
    t += n;
    chk(t, 32'h0);
    xr(OP_STORE_SUM, 2'h2, 32'h0, 32'h0, 32'h6, n);
    chk(n, 32'h0);
    xr(OP_STORE_SUM, 2'h3, 32'h0, 32'h0, 32'h100, n);
    xr(OP_STORE_UPPER, 2'h2, 32'h0, 32'h0, 32'hffc00000, n);
    xr(OP_STORE_SUM, 2'h1, 32'h0, 32'h0, 32'h80000001, n);
    xr(OP_STORE_UPPER, 2'h0, 32'h0, 32'h0, 32'hffff0000, n);
    $display("t_b2b done");
  endtask
  task automatic t_filter();
    int n;
    put(OP_LOAD_FILTER, 2'h0, 2'h0, 32'h0, 32'h1234abcd, 1'b1, n);
    @(posedge sys_clk);
    xr(OP_STORE_FILTER, 2'h0, 32'h0, 32'h0, 32'hffffabcd, n);
    for (int f = 0; f < 2; f++) begin
      with_load <= 1'b1;
      filter_en <= f[0];
      ea_addr <= 32'h12345678;
      mem_data <= 32'hcafe0001 + 32'(f);
      load_idx <= 4'h9;
      put(OP_MULTIPLY_ADD, 2'h1, 2'h0, 32'h1, 32'h1, 1'b1, n);
      wv(1);
      chk(ld_data, 32'hcafe0001 + 32'(f));
      chk({28'h0, ld_idx}, 32'h9);
      chk(addr_out, f ? 32'h12340248 : 32'h12345678);
      @(posedge sys_clk);
    end
    // Dropped only after the loop so no edge sees it assigned twice
    with_load <= 1'b0;
    $display("t_filter done");
  endtask
  task automatic t_upper();
    int n;
    put(OP_LOAD_UPPER, 2'h2, 2'h0, 32'h0, 32'hbeef1234, 1'b1, n);
    @(posedge sys_clk);
    xr(OP_STORE_UPPER, 2'h2, 32'h0, 32'h0, 32'hbeef1234, n);
    xr(OP_STORE_SUM, 2'h2, 32'h0, 32'h0, 32'h6, n);
    put(OP_LOAD_STATUS, 2'h0, 2'h0, 32'h0, 32'hd, 1'b1, n);
    @(posedge sys_clk);
    xr(OP_STORE_STATUS, 2'h0, 32'h0, 32'h0, 32'hd, n);
    put(OP_STATUS_TO_CC, 2'h0, 2'h0, 32'h0, 32'h0, 1'b1, n);
    wv(2);
    chk({27'h0, cc_flags}, 32'hd);
    @(posedge sys_clk);
    $display("t_upper done");
  endtask
  // ------
  // Main sequence
  // ------
  initial begin
    rst = 1'b1;
    with_load = 1'b0;
    filter_en = 1'b0;
    ea_addr = 32'h0;
    mem_data = 32'h0;
    load_idx = 4'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_frac();
    t_b2b();
    t_filter();
    t_upper();
    wrap_up();
  end
endmodule // multiply_accumulate_instruction_unit_tb
`default_nettype wire
